// File: inc/pccu_cfg.svh
// Offsets, field positions, reset values and timing counts of the clock unit
`ifndef PCCU_CFG_SVH
`define PCCU_CFG_SVH

`define PCCU_ADDR_MODE 8'hEB
`define PCCU_ADDR_CLOCK_CONTROL 8'hF0
`define PCCU_ADDR_FLAGS 8'hF2
`define PCCU_ADDR_PLLCFG 8'hF6

`define PCCU_RST_MODE 8'hE0
`define PCCU_RST_CLOCK_CONTROL 8'h00
`define PCCU_RST_FLAGS 8'h08
`define PCCU_RST_PLLCFG 8'h07
`define PCCU_FLAGS_WMASK 8'h09
`define PCCU_RD_UNMAPPED 8'h00

`define PCCU_MODE_HALVE 5
`define PCCU_MODE_PRS_HI 4
`define PCCU_MODE_PRS_LO 2
`define PCCU_CTL_INTSEL 7
`define PCCU_CTL_SRESEN 3
`define PCCU_CTL_AUXSEL 2
`define PCCU_CTL_WFISEL 1
`define PCCU_CTL_LPWFI 0
`define PCCU_FLG_MSEL 0
`define PCCU_FLG_LOCK 1
`define PCCU_FLG_AUXST 2
`define PCCU_FLG_XTDIV16 3
`define PCCU_FLG_RSVD 4
`define PCCU_FLG_HWRST 5
`define PCCU_FLG_SWRST 6
`define PCCU_FLG_WDRST 7
`define PCCU_PLL_DIV_HI 2
`define PCCU_PLL_DIV_LO 0
`define PCCU_PLL_MUL_HI 5
`define PCCU_PLL_MUL_LO 4

`define PCCU_DIV_OFF 3'h7
`define PCCU_MUL_CODE14 2'h2
`define PCCU_MUL_CODE10 2'h0
`define PCCU_MUL_CODE8 2'h3
`define PCCU_MULT_X14 5'h0E
`define PCCU_MULT_X10 5'h0A
`define PCCU_MULT_X8 5'h08
`define PCCU_MULT_X6 5'h06
`define PCCU_DIV16_LAST 4'hF
`define PCCU_LOCK_MATCH 2'h2

`define PCCU_CLK_NS 100
`define PCCU_OSC_HALF_NS 2800
`define PCCU_AUX_HALF_NS 5882
`define PCCU_OSC_CYC (`PCCU_OSC_HALF_NS / `PCCU_CLK_NS)
`define PCCU_AUX_CYC (`PCCU_AUX_HALF_NS / `PCCU_CLK_NS)

`endif

// File: inc/pccu_pkg.sv
// Types shared by the clock unit files
package pccu_pkg;
	typedef enum logic [2:0] {
		SRC_REF = 3'b000,
		SRC_REF16 = 3'b001,
		SRC_PLL = 3'b010,
		SRC_AUX = 3'b011,
		SRC_AUX16 = 3'b100
	} pccu_src_t;
endpackage

// File: design/pccu_rate_gen.sv
// Fractional rate generator: inc edges per modulo cycles
`timescale 1ns/1ps
module pccu_rate_gen
(
	input wire logic clk, // Unit clock
	input wire logic rst_b, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic run, // Generator running
	input wire logic [4:0] inc, // Edges per window
	input wire logic [7:0] modulo, // Window length in cycles
	output logic tick // One-cycle edge strobe
);
	logic [7:0] acc;
	wire [8:0] sum = {1'b0, acc} + {4'h0, inc};
	wire wrap = sum >= {1'b0, modulo};
	wire [8:0] next_acc = wrap ? sum - {1'b0, modulo} : sum;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			acc <= 8'h00;
			tick <= 1'b0;
		end
		else if (ce)
		begin
			// Restart from zero so a fresh start has a known phase
			acc <= run ? next_acc[7:0] : 8'h00;
			tick <= run & wrap;
		end
	end
endmodule // pccu_rate_gen

// File: design/pccu_clock_unit.sv
// Clock control unit: reference, multiplier, source switch, prescaler, registers
//
// Notes on behaviour
// - Halving bit set at reset makes reference the oscillator halved, else undivided.
// - Active multiplier multiplies reference by 6, 8, 10 or 14 per field.
// - Multiplied clock is divided by post-divider field plus one, one to seven.
// - Post-divider all ones switches the multiplier off.
// - Writing any other post-divider code after reset powers the multiplier up.
// - Multiplier-select flag bit switches system clock to the divided multiplier.
// - Lock logic compares multiplier with reference and sets the lock flag.
// - With multiplier off the system clock may be reference divided by sixteen.
// - Auxiliary RC clock is a source, divided by sixteen in low-power wait.
// - System clock feeds all peripherals and the core clock prescaler.
// - Prescaler slows the core clock up to eight times, peripherals unchanged.
// - Undivided multiplier output is given out for a high-speed peripheral.
// - Reset origin hardware, software or watchdog is recorded in flags.
// - External stop input freezes all oscillators.
// - Clock control register holds low-power settings and halt interpretation.
// - Prescale zero gives core equal to system clock, N divides by N+1.
// - Low-power wait stops multiplier, forces reference/16 or auxiliary/16 clock.
// - Selecting or leaving auxiliary or divided-by-16 clock raises a maskable interrupt.
`timescale 1ns/1ps
`include "pccu_cfg.svh"
module pccu_clock_unit
(
	input wire logic CLOCK, // Unit clock, 10 MHz
	input wire logic RST_B, // Async reset, active low
	input wire logic CE, // Clock enable, freezes all state when low
	input wire logic [7:0] REG_ADDR, // Register number
	input wire logic [7:0] REG_WDATA, // Write data
	input wire logic REG_WR, // Write strobe
	input wire logic REG_RD, // Read strobe
	input wire logic WFI_EXEC, // Core executes wait-for-interrupt
	input wire logic WAKE, // Interrupt ends the wait
	input wire logic HALT_EXEC, // Core executes halt
	input wire logic WDG_RESET, // Watchdog reset event
	input wire logic STOP_PIN, // External stop request, asynchronous
	output logic [7:0] REG_RDATA, // Read data, one cycle after strobe
	output logic SYS_CLK, // System clock to peripherals
	output logic CORE_CLK, // Prescaled core clock
	output logic PLL_CLK, // Undivided multiplier clock
	output logic CLK_INT_B, // Clock interrupt, low pulse
	output logic SW_RESET_REQ // Software reset request pulse
);
	////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] mode_control;
	logic [7:0] clock_control;
	logic [7:0] flags_ctl;
	logic [7:0] pll_config;
	logic lock;
	logic hw_flag;
	logic sw_flag;
	logic wd_flag;
	logic wfi_active;
	logic stop_s1;
	logic stop_s2;
	logic stop_prev;
	logic ref_ph;
	logic [3:0] ref16_cnt;
	logic [3:0] aux16_cnt;
	logic [2:0] pdiv_cnt;
	logic [4:0] lk_cnt;
	logic [1:0] lk_good;
	logic [2:0] pcnt;
	pccu_pkg::pccu_src_t cur_src;
	pccu_pkg::pccu_src_t req_src;
	logic src_tick;
	logic osc_tick;
	logic aux_tick;
	logic pll_tick;

	wire wr_mode = REG_WR && (REG_ADDR == `PCCU_ADDR_MODE);
	wire wr_ctl = REG_WR && (REG_ADDR == `PCCU_ADDR_CLOCK_CONTROL);
	wire wr_flags = REG_WR && (REG_ADDR == `PCCU_ADDR_FLAGS);
	wire wr_pll = REG_WR && (REG_ADDR == `PCCU_ADDR_PLLCFG);

	wire halve = mode_control[`PCCU_MODE_HALVE];
	wire [2:0] prs = mode_control[`PCCU_MODE_PRS_HI:`PCCU_MODE_PRS_LO];
	wire int_sel = clock_control[`PCCU_CTL_INTSEL];
	wire sresen = clock_control[`PCCU_CTL_SRESEN];
	wire aux_sel = clock_control[`PCCU_CTL_AUXSEL];
	wire wfi_cksel = clock_control[`PCCU_CTL_WFISEL];
	wire lp_en = clock_control[`PCCU_CTL_LPWFI];
	wire msel = flags_ctl[`PCCU_FLG_MSEL];
	wire xt_div16 = flags_ctl[`PCCU_FLG_XTDIV16];
	wire [2:0] pdiv = pll_config[`PCCU_PLL_DIV_HI:`PCCU_PLL_DIV_LO];
	wire [1:0] mcode = pll_config[`PCCU_PLL_MUL_HI:`PCCU_PLL_MUL_LO];
	wire stop_now = stop_s2;
	wire lp_wfi = wfi_active && lp_en;
	wire aux_st = (cur_src == pccu_pkg::SRC_AUX) || (cur_src == pccu_pkg::SRC_AUX16);

	////////////////////////////////////////////////////////////////
	// Reference and auxiliary clocks
	// oscillators frozen
	pccu_rate_gen u_osc
	(
		.clk(CLOCK),
		.rst_b(RST_B),
		.ce(CE),
		.run(!stop_now),
		.inc(5'h01),
		.modulo(8'(`PCCU_OSC_CYC)),
		.tick(osc_tick)
	);

	pccu_rate_gen u_aux
	(
		.clk(CLOCK),
		.rst_b(RST_B),
		.ce(CE),
		.run(!stop_now),
		.inc(5'h01),
		.modulo(8'(`PCCU_AUX_CYC)),
		.tick(aux_tick)
	);

	wire ref_tick = osc_tick && (!halve || ref_ph);
	wire [7:0] ref_mod = halve ? 8'(2 * `PCCU_OSC_CYC) : 8'(`PCCU_OSC_CYC);
	wire ref16_tick = ref_tick && (ref16_cnt == `PCCU_DIV16_LAST);
	wire aux16_tick = aux_tick && (aux16_cnt == `PCCU_DIV16_LAST);

	////////////////////////////////////////////////////////////////
	// Multiplier
	// factor decode
	wire [4:0] mult = (mcode == `PCCU_MUL_CODE14) ? `PCCU_MULT_X14 :
		(mcode == `PCCU_MUL_CODE10) ? `PCCU_MULT_X10 :
		(mcode == `PCCU_MUL_CODE8) ? `PCCU_MULT_X8 : `PCCU_MULT_X6;
	wire pll_on = (pdiv != `PCCU_DIV_OFF) && !lp_wfi;
	// Kept running until the switch leaves it, else the switch would starve
	wire pll_run = (pll_on || (cur_src == pccu_pkg::SRC_PLL)) && !stop_now;

	pccu_rate_gen u_pll
	(
		.clk(CLOCK),
		.rst_b(RST_B),
		.ce(CE),
		.run(pll_run),
		.inc(mult),
		.modulo(ref_mod),
		.tick(pll_tick)
	);

	wire pdiv_tick = pll_tick && (pdiv_cnt == pdiv);

	////////////////////////////////////////////////////////////////
	// Source request and glitch-free switch
	always_comb
	begin
		if (lp_wfi)
			req_src = (wfi_cksel && aux_sel) ? pccu_pkg::SRC_AUX16 : pccu_pkg::SRC_REF16;
		else if (aux_sel)
			req_src = pccu_pkg::SRC_AUX;
		else if (!xt_div16)
			req_src = pccu_pkg::SRC_REF16;
		else if (msel && pll_on)
			req_src = pccu_pkg::SRC_PLL;
		else
			req_src = pccu_pkg::SRC_REF;
	end

	always_comb
	begin
		case (cur_src)
			pccu_pkg::SRC_REF: src_tick = ref_tick;
			pccu_pkg::SRC_REF16: src_tick = ref16_tick;
			pccu_pkg::SRC_PLL: src_tick = pdiv_tick;
			pccu_pkg::SRC_AUX: src_tick = aux_tick;
			pccu_pkg::SRC_AUX16: src_tick = aux16_tick;
			default: src_tick = ref_tick;
		endcase
	end

	wire switch_go = (req_src != cur_src) && !SYS_CLK && src_tick;
	wire sys_rise = src_tick && !switch_go && !SYS_CLK;
	wire sys_fall = src_tick && SYS_CLK;
	wire cur_slow = (cur_src == pccu_pkg::SRC_REF16) || aux_st;
	wire req_slow = (req_src == pccu_pkg::SRC_REF16) || (req_src == pccu_pkg::SRC_AUX)
		|| (req_src == pccu_pkg::SRC_AUX16);
	wire clk_evt = int_sel && ((switch_go && (cur_slow || req_slow)) || (stop_prev && !stop_now));
	wire sw_evt = HALT_EXEC && sresen;

	////////////////////////////////////////////////////////////////
	// Register file
	wire [7:0] flags_rd;
	assign flags_rd[`PCCU_FLG_MSEL] = msel;
	assign flags_rd[`PCCU_FLG_LOCK] = lock;
	assign flags_rd[`PCCU_FLG_AUXST] = aux_st;
	assign flags_rd[`PCCU_FLG_XTDIV16] = xt_div16;
	assign flags_rd[`PCCU_FLG_RSVD] = 1'b0;
	assign flags_rd[`PCCU_FLG_HWRST] = hw_flag;
	assign flags_rd[`PCCU_FLG_SWRST] = sw_flag;
	assign flags_rd[`PCCU_FLG_WDRST] = wd_flag;
	wire [7:0] rd_value = (REG_ADDR == `PCCU_ADDR_MODE) ? mode_control :
		(REG_ADDR == `PCCU_ADDR_CLOCK_CONTROL) ? clock_control :
		(REG_ADDR == `PCCU_ADDR_FLAGS) ? flags_rd :
		(REG_ADDR == `PCCU_ADDR_PLLCFG) ? pll_config : `PCCU_RD_UNMAPPED;

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			mode_control <= `PCCU_RST_MODE;
			clock_control <= `PCCU_RST_CLOCK_CONTROL;
			flags_ctl <= `PCCU_RST_FLAGS;
			pll_config <= `PCCU_RST_PLLCFG;
			REG_RDATA <= 8'h00;
		end
		else if (CE)
		begin
			if (wr_mode)
				mode_control <= REG_WDATA;
			if (wr_ctl)
				clock_control <= REG_WDATA;
			if (wr_flags)
				flags_ctl <= REG_WDATA & `PCCU_FLAGS_WMASK;
			if (wr_pll)
				pll_config <= REG_WDATA;
			if (REG_RD)
				REG_RDATA <= rd_value;
		end
	end

	////////////////////////////////////////////////////////////////
	// Reset origin, wait state and stop input
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			hw_flag <= 1'b1;
			sw_flag <= 1'b0;
			wd_flag <= 1'b0;
			SW_RESET_REQ <= 1'b0;
			wfi_active <= 1'b0;
			stop_s1 <= 1'b0;
			stop_s2 <= 1'b0;
			stop_prev <= 1'b0;
		end
		else if (CE)
		begin
			if (sw_evt || WDG_RESET)
			begin
				hw_flag <= 1'b0;
				sw_flag <= sw_evt && !WDG_RESET;
				wd_flag <= WDG_RESET;
			end
			SW_RESET_REQ <= sw_evt;
			// Entry wins over a wake in the same cycle
			wfi_active <= WFI_EXEC || (wfi_active && !WAKE);
			stop_s1 <= STOP_PIN;
			stop_s2 <= stop_s1;
			stop_prev <= stop_now;
		end
	end

	////////////////////////////////////////////////////////////////
	// Dividers, lock detect and clock outputs
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			ref_ph <= 1'b0;
			ref16_cnt <= 4'h0;
			aux16_cnt <= 4'h0;
			pdiv_cnt <= 3'h0;
			PLL_CLK <= 1'b0;
		end
		else if (CE)
		begin
			if (osc_tick)
				ref_ph <= halve && !ref_ph;
			if (ref_tick)
				ref16_cnt <= ref16_cnt + 4'h1;
			if (aux_tick)
				aux16_cnt <= aux16_cnt + 4'h1;
			if (pll_tick)
				pdiv_cnt <= pdiv_tick ? 3'h0 : pdiv_cnt + 3'h1;
			if (pll_tick)
				PLL_CLK <= !PLL_CLK;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			lk_cnt <= 5'h00;
			lk_good <= 2'h0;
			lock <= 1'b0;
		end
		else if (CE)
		begin
			if (!pll_on)
			begin
				lk_cnt <= 5'h00;
				lk_good <= 2'h0;
				lock <= 1'b0;
			end
			else if (ref_tick)
			begin
				lk_cnt <= {4'h0, pll_tick};
				lk_good <= (lk_cnt != mult) ? 2'h0 :
					(lk_good == `PCCU_LOCK_MATCH) ? lk_good : lk_good + 2'h1;
				lock <= (lk_cnt == mult) && (lk_good >= `PCCU_LOCK_MATCH - 2'h1);
			end
			else if (pll_tick)
				lk_cnt <= lk_cnt + 5'h01;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			cur_src <= pccu_pkg::SRC_REF;
			SYS_CLK <= 1'b0;
			CORE_CLK <= 1'b0;
			pcnt <= 3'h0;
			CLK_INT_B <= 1'b1;
		end
		else if (CE)
		begin
			if (switch_go)
				cur_src <= req_src;
			else if (src_tick)
				SYS_CLK <= !SYS_CLK;
			if (sys_rise)
				CORE_CLK <= 1'b1;
			if (sys_fall && !wfi_active)
			begin
				pcnt <= (pcnt >= prs) ? 3'h0 : pcnt + 3'h1;
				if (pcnt >= prs)
					CORE_CLK <= 1'b0;
			end
			CLK_INT_B <= !clk_evt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B || !CE);

	sequence sw_request;
		HALT_EXEC && sresen && !WDG_RESET;
	endsequence

	sequence sw_recorded;
		SW_RESET_REQ && sw_flag && !hw_flag;
	endsequence

	halve_ref_a: assert property ((osc_tick && !halve) |-> ref_tick ##1 !ref_ph)
		else $error("undivided reference missed an edge");
	halve_skip_a: assert property ((osc_tick && halve && !ref_ph) |-> !ref_tick ##1 ref_ph)
		else $error("halved reference took every edge");
	pll_off_a: assert property ((pdiv == `PCCU_DIV_OFF && cur_src != pccu_pkg::SRC_PLL) |=> !pll_tick)
		else $error("multiplier runs with divider all ones");
	lock_drop_a: assert property (!pll_on |=> !lock)
		else $error("lock flag set while multiplier off");
	lock_rise_a: assert property ($rose(lock) |-> $past(ref_tick) && $past(lk_cnt) == $past(mult))
		else $error("lock set without a matching window");
	msel_pll_a: assert property ((msel && pll_on && !aux_sel && xt_div16) |-> req_src == pccu_pkg::SRC_PLL)
		else $error("multiplier select ignored");
	lp_wait_a: assert property ((lp_wfi && !aux_sel) |-> req_src == pccu_pkg::SRC_REF16 && !pll_on)
		else $error("low-power wait source wrong");
	glitch_free_a: assert property (switch_go |-> !SYS_CLK ##1 !SYS_CLK)
		else $error("system clock moved during a switch");
	core_equal_a: assert property ((prs == 3'h0 && !wfi_active && sys_fall) |=> !CORE_CLK)
		else $error("core clock not following system clock");
	irq_pulse_a: assert property ((switch_go && int_sel && req_src == pccu_pkg::SRC_REF16) |=> !CLK_INT_B)
		else $error("clock interrupt not raised on switch");
	sw_flag_a: assert property (sw_request |=> sw_recorded)
		else $error("software reset not recorded");
endmodule // pccu_clock_unit

// File: testbench/tb_pccu_clock_unit.sv
// Self-checking bench for the clock control unit
`timescale 1ns/1ps
module tb_pccu_clock_unit;
	logic CLOCK, RST_B, CE, REG_WR, REG_RD, WFI_EXEC, WAKE, HALT_EXEC, WDG_RESET, STOP_PIN;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
	logic SYS_CLK, CORE_CLK, PLL_CLK, CLK_INT_B, SW_RESET_REQ;
	logic ps, pc, pp;
	int n_fail, tests_run, st, cr, pt, ni, ns, s, c, p, k, i0;
	logic [1:0] codes [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
	int mults [4] = '{14, 10, 8, 6};

	pccu_clock_unit dut
	(
		.CLOCK(CLOCK),
		.RST_B(RST_B),
		.CE(CE),
		.REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR),
		.REG_RD(REG_RD),
		.WFI_EXEC(WFI_EXEC),
		.WAKE(WAKE),
		.HALT_EXEC(HALT_EXEC),
		.WDG_RESET(WDG_RESET),
		.STOP_PIN(STOP_PIN),
		.REG_RDATA(REG_RDATA),
		.SYS_CLK(SYS_CLK),
		.CORE_CLK(CORE_CLK),
		.PLL_CLK(PLL_CLK),
		.CLK_INT_B(CLK_INT_B),
		.SW_RESET_REQ(SW_RESET_REQ)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end

	// Edge and pulse counters; generated clocks are slow against CLOCK
	always @(posedge CLOCK)
	begin
		ps <= SYS_CLK;
		pc <= CORE_CLK;
		pp <= PLL_CLK;
		if (SYS_CLK !== ps) st++;
		if (CORE_CLK === 1'b1 && pc === 1'b0) cr++;
		if (PLL_CLK !== pp) pt++;
		if (CLK_INT_B === 1'b0) ni++;
		if (SW_RESET_REQ === 1'b1) ns++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task stop_test;
	begin
		$display("checks=%0d fails=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask

	task chk8(input logic [7:0] g, input logic [7:0] e);
	begin
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	end
	endtask

	// Counts drift by an edge depending on window phase
	task chkn(input int g, input int e, input int tol);
	begin
		tests_run++;
		if (g < e - tol || g > e + tol)
		begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	end
	endtask

	task wt(input int n);
	begin
		repeat (n) @(negedge CLOCK);
	end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
	begin
		@(negedge CLOCK);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		@(negedge CLOCK);
		REG_WR = 1'b0;
	end
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
	begin
		@(negedge CLOCK);
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(negedge CLOCK);
		REG_RD = 1'b0;
		chk8(REG_RDATA, e);
	end
	endtask

	task automatic pulse(ref logic sig);
		@(negedge CLOCK);
		sig = 1'b1;
		@(negedge CLOCK);
		sig = 1'b0;
	endtask

	task meas(input int n);
	begin
		s = st;
		c = cr;
		p = pt;
		wt(n);
		s = st - s;
		c = cr - c;
		p = pt - p;
	end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(100 * 90000);
		n_fail++;
		stop_test;
	end

	initial
	begin
		{RST_B, REG_WR, REG_RD, WFI_EXEC, WAKE, HALT_EXEC, WDG_RESET, STOP_PIN} = 8'h00;
		CE = 1'b1;
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		wt(20);
		RST_B = 1'b1;
		rd(8'hEB, 8'hE0);
		rd(8'hF0, 8'h00);
		rd(8'hF2, 8'h28);
		rd(8'hF6, 8'h07);
		wr(8'h10, 8'hFF);
		rd(8'h10, 8'h00);
		wt(300);
		meas(2240);
		chkn(s, 40, 2);
		chkn(p, 0, 0);
		// Read-only flag bits must not take the write
		wr(8'hF2, 8'hFF);
		rd(8'hF2, 8'h29);
		wr(8'hF2, 8'h08);
		wr(8'hEB, 8'hC0);
		wt(300);
		meas(2240);
		chkn(s, 80, 2);
		for (k = 0; k < 8; k++)
		begin
			wr(8'hEB, 8'hC0 | 8'(k << 2));
			wt(300);
			meas(2240);
			chkn(s, 80, 2);
			chkn(c, 40 / (k + 1), 1);
		end
		wr(8'hEB, 8'hC0);
		for (k = 0; k < 4; k++)
		begin
			wr(8'hF6, {2'b00, codes[k], 4'h1});
			wt(300);
			meas(280);
			chkn(p, mults[k] * 10, 2);
			rd(8'hF2, 8'h2A);
		end
		wr(8'hF2, 8'h09);
		for (k = 0; k < 7; k++)
		begin
			// Factor six keeps the edge counts of this loop small
			wr(8'hF6, 8'h10 | 8'(k));
			wt(300);
			meas(280);
			chkn(s, 60 / (k + 1), 2);
			chkn(p, 60, 2);
		end
		wr(8'hF6, 8'h07);
		wt(300);
		meas(280);
		chkn(p, 0, 0);
		chkn(s, 10, 1);
		rd(8'hF2, 8'h29);
		wr(8'hF2, 8'h08);
		wr(8'hF0, 8'h80);
		i0 = ni;
		wr(8'hF2, 8'h00);
		wt(1000);
		meas(4480);
		chkn(s, 10, 1);
		chkn(ni - i0, 1, 0);
		wr(8'hF2, 8'h08);
		wt(1000);
		chkn(ni - i0, 2, 0);
		wr(8'hF0, 8'h84);
		wt(1000);
		meas(2320);
		chkn(s, 40, 2);
		rd(8'hF2, 8'h2C);
		chkn(ni - i0, 3, 0);
		wr(8'hF0, 8'h81);
		wt(1000);
		pulse(WFI_EXEC);
		wt(1000);
		meas(4480);
		chkn(s, 10, 1);
		chkn(c, 0, 0);
		chk8({7'h00, CORE_CLK}, 8'h01);
		pulse(WAKE);
		wt(1000);
		meas(2240);
		chkn(s, 80, 2);
		wr(8'hF0, 8'h87);
		wt(200);
		pulse(WFI_EXEC);
		wt(200);
		meas(4640);
		chkn(s, 5, 1);
		rd(8'hF2, 8'h2C);
		pulse(WAKE);
		// Leaving the slow source takes up to two of its edges
		wr(8'hF0, 8'h80);
		wt(2000);
		STOP_PIN = 1'b1;
		wt(10);
		i0 = ni;
		meas(500);
		chkn(s + p, 0, 0);
		STOP_PIN = 1'b0;
		wt(300);
		chkn(ni - i0, 1, 0);
		CE = 1'b0;
		meas(500);
		chkn(s, 0, 0);
		CE = 1'b1;
		// Halt is only a reset request when enabled
		pulse(HALT_EXEC);
		wt(3);
		chkn(ns, 0, 0);
		wr(8'hF0, 8'h88);
		pulse(HALT_EXEC);
		wt(3);
		chkn(ns, 1, 0);
		rd(8'hF2, 8'h48);
		pulse(WDG_RESET);
		rd(8'hF2, 8'h88);
		stop_test;
	end
endmodule // tb_pccu_clock_unit
